// ==== design/bsiu_defs.vh ====
`ifndef BSIU_DEFS_VH
`define BSIU_DEFS_VH
`define BSIU_IR_W 3
`define BSIU_OP_EXTEST 3'h0
`define BSIU_OP_RING1 3'h1
`define BSIU_OP_CFGW 3'h2
`define BSIU_OP_IDCODE 3'h3
`define BSIU_OP_SAMPLE 3'h4
`define BSIU_OP_RING2 3'h5
`define BSIU_OP_CFGR 3'h6
`define BSIU_OP_BYPASS 3'h7
`define BSIU_IR_CAPTURE 3'h1
`define BSIU_ID_W 32
`define BSIU_ST_RESET 4'hF
`define BSIU_ST_IDLE 4'hC
`define BSIU_ST_SEL_DR 4'h7
`define BSIU_ST_CAP_DR 4'h6
`define BSIU_ST_SHIFT_DR 4'h2
`define BSIU_ST_EXIT1_DR 4'h1
`define BSIU_ST_PAUSE_DR 4'h3
`define BSIU_ST_EXIT2_DR 4'h0
`define BSIU_ST_UPD_DR 4'h5
`define BSIU_ST_SEL_IR 4'h4
`define BSIU_ST_CAP_IR 4'hE
`define BSIU_ST_SHIFT_IR 4'hA
`define BSIU_ST_EXIT1_IR 4'h9
`define BSIU_ST_PAUSE_IR 4'hB
`define BSIU_ST_EXIT2_IR 4'h8
`define BSIU_ST_UPD_IR 4'hD
`endif

// ==== design/bsiu_tap_fsm.v ====
`timescale 1ns/1ps
`include "bsiu_defs.vh"
module bsiu_tap_fsm (
   input wire sys_clk,
   input wire rstn,
   input wire tck_rise,
   input wire tms,
   output reg [3:0] state
);
   reg [3:0] next_state;
   always @* begin
      case (state)
         `BSIU_ST_RESET: next_state = tms ? `BSIU_ST_RESET : `BSIU_ST_IDLE;
         `BSIU_ST_IDLE: next_state = tms ? `BSIU_ST_SEL_DR : `BSIU_ST_IDLE;
         `BSIU_ST_SEL_DR: next_state = tms ? `BSIU_ST_SEL_IR : `BSIU_ST_CAP_DR;
         `BSIU_ST_CAP_DR: next_state = tms ? `BSIU_ST_EXIT1_DR :
            `BSIU_ST_SHIFT_DR;
         `BSIU_ST_SHIFT_DR: next_state = tms ? `BSIU_ST_EXIT1_DR :
            `BSIU_ST_SHIFT_DR;
         `BSIU_ST_EXIT1_DR: next_state = tms ? `BSIU_ST_UPD_DR :
            `BSIU_ST_PAUSE_DR;
         `BSIU_ST_PAUSE_DR: next_state = tms ? `BSIU_ST_EXIT2_DR :
            `BSIU_ST_PAUSE_DR;
         `BSIU_ST_EXIT2_DR: next_state = tms ? `BSIU_ST_UPD_DR :
            `BSIU_ST_SHIFT_DR;
         `BSIU_ST_UPD_DR: next_state = tms ? `BSIU_ST_SEL_DR : `BSIU_ST_IDLE;
         `BSIU_ST_SEL_IR: next_state = tms ? `BSIU_ST_RESET : `BSIU_ST_CAP_IR;
         `BSIU_ST_CAP_IR: next_state = tms ? `BSIU_ST_EXIT1_IR :
            `BSIU_ST_SHIFT_IR;
         `BSIU_ST_SHIFT_IR: next_state = tms ? `BSIU_ST_EXIT1_IR :
            `BSIU_ST_SHIFT_IR;
         `BSIU_ST_EXIT1_IR: next_state = tms ? `BSIU_ST_UPD_IR :
            `BSIU_ST_PAUSE_IR;
         `BSIU_ST_PAUSE_IR: next_state = tms ? `BSIU_ST_EXIT2_IR :
            `BSIU_ST_PAUSE_IR;
         `BSIU_ST_EXIT2_IR: next_state = tms ? `BSIU_ST_UPD_IR :
            `BSIU_ST_SHIFT_IR;
         `BSIU_ST_UPD_IR: next_state = tms ? `BSIU_ST_SEL_DR : `BSIU_ST_IDLE;
         default: next_state = `BSIU_ST_RESET;
      endcase
   end
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         state <= `BSIU_ST_RESET;
      else if (tck_rise)
         state <= next_state; // [R15]
   end
endmodule

// ==== design/bsiu_top.v ====
`timescale 1ns/1ps
`include "bsiu_defs.vh"
// Behaviour
// R1 - four test pins; reconfigure pin resets all scan logic too.
// R2 - 3-bit instruction register decoding nine instructions; the code decodes eight opcodes.
// R3 - code 001 is ring one or user identity, set by option.
// R4 - rings one and two route tdi to tdo through user chain.
// R5 - code 010 loads configuration data serially from tdi.
// R6 - code 110 shifts configuration memory out after configuration.
// R7 - extest, sample/preload, bypass at 111, and idcode provided.
// R8 - extest uses two boundary bits per pad: value and enable.
// R9 - enable bit chooses driving pad or capturing its input.
// R10 - sample captures pad level and enable together; normal use continues.
// R11 - update transfers boundary contents to all pads at once.
// R12 - code 011 captures 32-bit identity and shifts it out.
// R13 - identity is version, part, family, maker, then lsb one.
// R14 - host chains tdo to tdi, drives tms and tck in parallel.
// R15 - sixteen controller states, stepped by tms on tck rise.
// R16 - bypass path is a single flip-flop.
// R17 - after test reset the identity register is selected.
// R18 - scan active before configuration; option decides afterwards.
// R19 - config write/read through serial port, one bit per tck.
module bsiu_top #(
   parameter NPADS = 4,
   parameter RING1_W = 8,
   parameter RING2_W = 8,
   parameter [3:0] ID_VERSION = 4'h0,
   parameter [9:0] ID_PART = 10'h155,
   parameter [5:0] ID_FAMILY = 6'h2A,
   parameter [10:0] ID_MAKER = 11'h2AA,
   parameter [10:0] USER_CODE = 11'h0F0
) (
   input wire sys_clk,
   input wire rstn,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo,
   output reg tdo_oe_n,
   input wire reconfigure_pin_n,
   input wire cfg_done,
   input wire opt_scan_keep,
   input wire opt_user_identity,
   input wire [NPADS-1:0] core_out,
   input wire [NPADS-1:0] core_oe_n,
   input wire [NPADS-1:0] pad_in,
   output wire [NPADS-1:0] pad_out,
   output wire [NPADS-1:0] pad_oe_n,
   output wire [NPADS-1:0] core_in,
   output reg ring_shift,
   output reg ring_si,
   input wire ring1_so,
   input wire ring2_so,
   output reg cfg_wr_en,
   output reg cfg_rd_en,
   output reg cfg_si,
   input wire cfg_so,
   output wire scan_active
);
   localparam BW = 2 * NPADS;
   reg [2:0] tck_s;
   reg [2:0] tms_s;
   reg [2:0] tdi_s;
   reg [1:0] prg_s;
   wire tck_rise = tck_s[1] & ~tck_s[2];
   wire tck_fall = ~tck_s[1] & tck_s[2];
   wire [3:0] state;
   reg [2:0] ir_sh;
   reg [2:0] ir;
   reg bypass_ff;
   reg [`BSIU_ID_W-1:0] id_sh;
   reg [BW-1:0] bsr_sh;
   reg [BW-1:0] bsr_upd;
   reg cfg_sel;
   wire scan_rst_n = rstn & prg_s[1];
   // during configuration boundary scan is always on
   assign scan_active = ~cfg_done | opt_scan_keep; // [R18]
   wire capture = tck_rise && state == `BSIU_ST_CAP_DR && scan_active;
   wire shift = tck_rise && state == `BSIU_ST_SHIFT_DR && scan_active;
   wire upd = tck_rise && state == `BSIU_ST_UPD_DR && scan_active;
   wire ring1_on = ir == `BSIU_OP_RING1 && !opt_user_identity; // [R3]
   wire user_id = ir == `BSIU_OP_RING1 && opt_user_identity; // [R3]
   wire ext_mode = ir == `BSIU_OP_EXTEST;
   wire [`BSIU_ID_W-1:0] id_val = {ID_VERSION, ID_PART, ID_FAMILY,
      user_id ? USER_CODE : ID_MAKER, 1'b1}; // [R13]
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tck_s <= 3'h0;
         tms_s <= 3'h7;
         tdi_s <= 3'h7;
         prg_s <= 2'h0;
      end else begin
         tck_s <= {tck_s[1:0], tck};
         tms_s <= {tms_s[1:0], tms};
         tdi_s <= {tdi_s[1:0], tdi};
         prg_s <= {prg_s[0], reconfigure_pin_n}; // [R1]
      end
   end
   bsiu_tap_fsm u_fsm (
      .sys_clk(sys_clk),
      .rstn(scan_rst_n),
      .tck_rise(tck_rise & scan_active),
      .tms(tms_s[1]),
      .state(state)
   );
   // instruction register; test reset leaves identity selected
   always @(posedge sys_clk or negedge scan_rst_n) begin
      if (!scan_rst_n) begin
         ir_sh <= 3'h0;
         ir <= `BSIU_OP_IDCODE; // [R1] [R17]
      end else if (state == `BSIU_ST_RESET) begin
         ir <= `BSIU_OP_IDCODE; // [R17]
      end else if (tck_rise && scan_active) begin
         if (state == `BSIU_ST_CAP_IR)
            ir_sh <= `BSIU_IR_CAPTURE;
         else if (state == `BSIU_ST_SHIFT_IR)
            ir_sh <= {tdi_s[1], ir_sh[2:1]}; // [R2]
         else if (state == `BSIU_ST_UPD_IR)
            ir <= ir_sh; // [R2]
      end
   end
   // data registers
   integer i;
   always @(posedge sys_clk or negedge scan_rst_n) begin
      if (!scan_rst_n) begin
         bypass_ff <= 1'b0;
         id_sh <= {`BSIU_ID_W{1'b0}};
         bsr_sh <= {BW{1'b0}};
         bsr_upd <= {BW{1'b0}};
      end else begin
         if (capture) begin
            bypass_ff <= 1'b0;
            id_sh <= id_val; // [R12]
            for (i = 0; i < NPADS; i = i + 1) begin
               // enable bit above value bit; enable decides what is seen
               bsr_sh[2*i+1] <= ext_mode ? bsr_upd[2*i+1] : core_oe_n[i];
               bsr_sh[2*i] <= (ext_mode && !bsr_upd[2*i+1]) ?
                  bsr_upd[2*i] : pad_in[i]; // [R9] [R10]
            end
         end else if (shift) begin
            bypass_ff <= tdi_s[1]; // [R16]
            id_sh <= {tdi_s[1], id_sh[`BSIU_ID_W-1:1]}; // [R12]
            bsr_sh <= {tdi_s[1], bsr_sh[BW-1:1]}; // [R8]
         end
         if (upd && (ext_mode || ir == `BSIU_OP_SAMPLE))
            bsr_upd <= bsr_sh; // [R11]
      end
   end
   genvar g;
   generate
      for (g = 0; g < NPADS; g = g + 1) begin : pads
         assign pad_out[g] = ext_mode ? bsr_upd[2*g] : core_out[g]; // [R9]
         assign pad_oe_n[g] = ext_mode ? bsr_upd[2*g+1] : core_oe_n[g];
         assign core_in[g] = pad_in[g]; // [R10]
      end
   endgenerate
   // serial ports to scan rings and configuration memory
   always @(posedge sys_clk or negedge scan_rst_n) begin
      if (!scan_rst_n) begin
         ring_shift <= 1'b0;
         ring_si <= 1'b0;
         cfg_wr_en <= 1'b0;
         cfg_rd_en <= 1'b0;
         cfg_si <= 1'b0;
         cfg_sel <= 1'b0;
      end else begin
         ring_shift <= shift && (ring1_on || ir == `BSIU_OP_RING2); // [R4]
         ring_si <= tdi_s[1]; // [R4]
         cfg_wr_en <= shift && ir == `BSIU_OP_CFGW; // [R5] [R19]
         cfg_rd_en <= shift && ir == `BSIU_OP_CFGR && cfg_done; // [R6] [R19]
         cfg_si <= tdi_s[1]; // [R5]
         cfg_sel <= cfg_done;
      end
   end
   reg tdo_mux;
   always @* begin
      tdo_mux = 1'b0;
      if (state == `BSIU_ST_SHIFT_IR)
         tdo_mux = ir_sh[0];
      else
         case (ir)
            `BSIU_OP_EXTEST: tdo_mux = bsr_sh[0];
            `BSIU_OP_SAMPLE: tdo_mux = bsr_sh[0];
            `BSIU_OP_RING1: tdo_mux = opt_user_identity ? id_sh[0] : ring1_so;
            `BSIU_OP_RING2: tdo_mux = ring2_so; // [R4]
            `BSIU_OP_IDCODE: tdo_mux = id_sh[0]; // [R12]
            `BSIU_OP_CFGR: tdo_mux = cfg_sel ? cfg_so : 1'b0; // [R6]
            `BSIU_OP_BYPASS: tdo_mux = bypass_ff; // [R7] [R16]
            default: tdo_mux = bypass_ff;
         endcase
   end
   // tdo changes on falling tck edge, per usual scan timing
   always @(posedge sys_clk or negedge scan_rst_n) begin
      if (!scan_rst_n) begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo <= tdo_mux; // [R1]
         tdo_oe_n <= !(scan_active && (state == `BSIU_ST_SHIFT_DR ||
            state == `BSIU_ST_SHIFT_IR));
      end
   end
endmodule

// ==== verif/bsiu_monitor.sv ====
`timescale 1ns/1ps
module bsiu_monitor #(
   parameter NPADS = 4
) (
   input wire sys_clk,
   input wire rstn,
   input wire tdo_oe_n,
   input wire reconfigure_pin_n,
   input wire cfg_done,
   input wire opt_scan_keep,
   input wire [NPADS-1:0] pad_in,
   input wire [NPADS-1:0] core_in,
   input wire ring_shift,
   input wire cfg_wr_en,
   input wire cfg_rd_en,
   input wire scan_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_active;
      scan_active == (!cfg_done || opt_scan_keep);
   endproperty
   a_active: assert property (p_active) else $error("scan enable wrong");
   property p_core;
      core_in == pad_in;
   endproperty
   a_core: assert property (p_core) else $error("core input lost");
   property p_rd_done;
      cfg_rd_en |-> cfg_done;
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("early readback");
   property p_wr_pulse;
      cfg_wr_en |=> !cfg_wr_en;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write too long");
   property p_ring_pulse;
      ring_shift |=> !ring_shift;
   endproperty
   a_ring_pulse: assert property (p_ring_pulse) else $error("ring too long");
   property p_oe;
      cfg_rd_en || cfg_wr_en || ring_shift |-> !tdo_oe_n;
   endproperty
   a_oe: assert property (p_oe) else $error("shift without drive");
   property p_one_op;
      ring_shift |-> !cfg_wr_en && !cfg_rd_en;
   endproperty
   a_one_op: assert property (p_one_op) else $error("two paths at once");
   property p_reconf;
      !reconfigure_pin_n [*5] |-> tdo_oe_n && !cfg_wr_en && !ring_shift;
   endproperty
   a_reconf: assert property (p_reconf) else $error("no scan reset");
   c_rd: cover property (cfg_rd_en);
   c_wr: cover property (cfg_wr_en);
   c_ring: cover property (ring_shift);
endmodule
bind bsiu_top bsiu_monitor #(.NPADS(NPADS)) u_bsiu_monitor (.*);

// ==== verif/bsiu_host.sv ====
`timescale 1ns/1ps
module bsiu_host (
   input wire sys_clk,
   output logic tck,
   output logic tms,
   output logic tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 80 ns test clock; tck rests low between frames
   task automatic clk(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (4) @(negedge sys_clk);
      tck = 1'b1;
      repeat (4) @(negedge sys_clk);
      tck = 1'b0;
      // step off the fall so the watcher sees it first
      #1;
   endtask
endmodule

// ==== verif/test_bsiu_top.sv ====
`timescale 1ns/1ps
module test_boundary_scan_instruction_unit;
   logic sys_clk = 1'b0, rstn = 1'b0, reconfigure_pin_n = 1'b1;
   logic cfg_done = 1'b0, opt_scan_keep = 1'b1, opt_user_identity = 1'b0;
   logic cfg_so = 1'b0, ring1_so = 1'b0, ring2_so = 1'b1;
   logic [3:0] core_out = 4'h0, core_oe_n = 4'hF, pad_in = 4'h0;
   wire tck, tms, tdi, tdo, tdo_oe_n, ring_shift, ring_si;
   wire cfg_wr_en, cfg_rd_en, cfg_si, scan_active;
   wire [3:0] pad_out, pad_oe_n, core_in;
   logic exp_q[$];
   logic [7:0] pre;
   logic [31:0] din;
   logic [7:0] wr_bits = 8'h00, ring_bits = 8'h00;
   int mismatches = 0, comparisons = 0, cycles = 0, seed = 6;
   // identity fields are arbitrary values
   localparam [31:0] ID = {4'h3, 10'h155, 6'h2A, 11'h2AA, 1'b1};
   localparam [31:0] UID = {4'h3, 10'h155, 6'h2A, 11'h0F0, 1'b1};
   always #5 sys_clk = ~sys_clk;
   bsiu_top #(.ID_VERSION(4'h3), .ID_PART(10'h155), .ID_FAMILY(6'h2A),
      .ID_MAKER(11'h2AA), .USER_CODE(11'h0F0)) u_bsiu_top (.*);
   bsiu_host u_bsiu_host (.*);
   task automatic end_sim;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (e !== g) begin
         mismatches++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   function automatic logic [7:0] bsr(input logic [3:0] v, e);
      for (int i = 0; i < 4; i++) begin
         bsr[2*i] = v[i];
         bsr[2*i+1] = e[i];
      end
   endfunction
   // extest capture: a driven pad keeps its preloaded value
   function automatic logic [7:0] ext(input logic [7:0] p,
      input logic [3:0] pin);
      ext = p;
      for (int i = 0; i < 4; i++)
         if (p[2*i+1]) ext[2*i] = pin[i];
   endfunction
   // far-side serial ports collect what the block shifts out to them
   always @(posedge sys_clk) begin
      if (cfg_wr_en) wr_bits <= {cfg_si, wr_bits[7:1]};
      if (ring_shift) ring_bits <= {ring_si, ring_bits[7:1]};
   end
   task automatic go(input logic m, input logic d = 1'b0);
      u_bsiu_host.clk(m, d);
   endtask
   // from idle: one capture, n shifts lsb first, update, back to idle
   task automatic scan(input bit ir, input int n, input logic [31:0] d,
      input logic [31:0] e, input bit c);
      go(1'b1);
      if (ir) go(1'b1);
      go(1'b0);
      go(1'b0);
      for (int i = 0; i < n; i++) begin
         if (c) exp_q.push_back(e[i]);
         go(i == n - 1, d[i]);
      end
      go(1'b1);
      go(1'b0);
   endtask
   always @(negedge tck)
      if (exp_q.size() > 0) check({7'h00, exp_q.pop_front()}, {7'h00, tdo});
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_sim;
      end
   end
   initial begin
      repeat (10) @(negedge sys_clk);
      rstn = 1'b1;
      pad_in = $random(seed);
      core_out = $random(seed);
      core_oe_n = $random(seed);
      pre = $random(seed);
      din = $random(seed);
      repeat (3) @(negedge sys_clk);
      go(1'b0);
      scan(0, 32, din, ID, 1);
      scan(1, 3, 32'h7, 32'h1, 1);
      scan(0, 9, din, {din[30:0], 1'b0}, 1);
      scan(1, 3, 32'h3, 32'h1, 1);
      scan(0, 32, 32'h0, ID, 1);
      scan(1, 3, 32'h4, 32'h1, 1);
      scan(0, 8, {24'h0, pre}, {24'h0, bsr(pad_in, core_oe_n)}, 1);
      check(bsr(pad_out, pad_oe_n), bsr(core_out, core_oe_n));
      scan(1, 3, 32'h0, 32'h1, 1);
      check(bsr(pad_out, pad_oe_n), pre);
      scan(0, 8, 32'h0, {24'h0, ext(pre, pad_in)}, 1);
      check(bsr(pad_out, pad_oe_n), 8'h00);
      opt_user_identity = 1'b1;
      scan(1, 3, 32'h1, 32'h1, 1);
      scan(0, 32, 32'h0, UID, 1);
      opt_user_identity = 1'b0;
      scan(1, 3, 32'h1, 32'h1, 1);
      scan(0, 8, din, 32'h0, 1);
      scan(1, 3, 32'h5, 32'h1, 1);
      scan(0, 8, din, 32'hFF, 1);
      check(ring_bits, din[7:0]);
      cfg_done = 1'b1;
      scan(1, 3, 32'h2, 32'h1, 1);
      scan(0, 8, din, 32'h0, 0);
      check(wr_bits, din[7:0]);
      cfg_so = 1'b1;
      scan(1, 3, 32'h6, 32'h1, 1);
      scan(0, 8, din, 32'hFF, 1);
      reconfigure_pin_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      reconfigure_pin_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(bsr(pad_out, pad_oe_n), bsr(core_out, core_oe_n));
      go(1'b0);
      scan(0, 32, din, ID, 1);
      end_sim;
   end
endmodule
